// ==== hw/sis_pkg.sv ====
// Package: register map, field layouts and constants of the I2C slave
package sis_pkg;
  localparam int unsigned    ADDR_W       = 8;
  localparam logic [7:0]     OFF_DATA     = 8'h00;
  localparam logic [7:0]     OFF_OWN_ADDR = 8'h04;
  localparam logic [7:0]     OFF_STATUS   = 8'h08;
  localparam logic [7:0]     OFF_CTRL0    = 8'h0c;
  localparam logic [7:0]     OFF_IRQ      = 8'h10;
  localparam logic [2:0]     MODE_I2C_SLV = 3'h6;
  localparam logic [7:0]     RST_CTRL0    = 8'he0;
  localparam logic [7:0]     RST_DATA     = 8'h00;
  localparam logic [7:0]     RST_OWN_ADDR = 8'h00;
  localparam logic [3:0]     BITS_PER_BYTE = 4'h8;
  localparam int unsigned    IRQ_MODULE_INTERRUPT_ENABLE_BIT = 0;
  localparam int unsigned    IRQ_MFE_BIT  = 1;
  localparam int unsigned    IRQ_PEND_BIT = 7;
  localparam logic [1:0]     RESP_OKAY    = 2'h0;
  localparam logic [1:0]     RESP_SLVERR  = 2'h2;

  typedef struct packed {
    logic done;
    logic match;
    logic busy;
    logic tx_sel;
    logic transmitted_ack_bit;
    logic rw;
    logic wake;
    logic received_ack_flag;
  } sis_status_t;

  typedef struct packed {
    logic [2:0] mode;
    logic [2:0] spare;
    logic       enable;
    logic       rsv;
  } sis_ctrl0_t;

  typedef struct packed {
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic sda;
  } sis_bus_ev_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_AACK,
    ST_HOLD,
    ST_DATA,
    ST_DACK,
    ST_WSTOP
  } sis_state_t;
endpackage

// ==== hw/sis_sync.sv ====
// Two flip-flop synchroniser for pin levels
module sis_sync import sis_pkg::*; #(
  parameter int unsigned W = 2
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  // Reset to ones: an idle bus floats high
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_q <= '1;
      q      <= '1;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// ==== hw/sis_edge.sv ====
// Bus condition detector: SCL edges, START and STOP
module sis_edge import sis_pkg::*; (
  input  wire logic  clock,
  input  wire logic  rst,
  input  wire logic  scl_s,
  input  wire logic  sda_s,
  output sis_bus_ev_t ev
);
  logic scl_p_q;
  logic sda_p_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  assign ev.scl_rise = scl_s & ~scl_p_q;
  assign ev.scl_fall = ~scl_s & scl_p_q;
  assign ev.start    = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign ev.stop     = scl_s & scl_p_q & ~sda_p_q & sda_s;
  assign ev.sda      = sda_s;
endmodule

// ==== hw/sis_i2c_slave.sv ====
// I2C slave of the shared serial module with AXI4-Lite registers
// Behaviour
// - One 8-bit data buffer holds bytes to send and bytes received.
// - Own address sits in bits 7..1; bit 0 is plain read/write storage.
// - Own address register is the same location as SPI control two.
// - SDA falling while SCL high is START; sets bus busy flag.
// - After START, first seven bits MSB first are compared with own address.
// - Address equal sets address match flag and raises interrupt.
// - Eighth bit after START is stored as master read flag; here it is stored only on an address match.
// - On match, SDA is driven low during the ninth clock.
// - One interrupt for address match or byte done; match flag tells which.
// - After match SCL held low until buffer write (tx) or dummy read (rx).
// - Software sets transmit select from master read flag; it sets direction.
// - Data bytes are eight bits, MSB first, after address acknowledge.
// - As receiver, transmitted ack bit goes onto SDA on ninth clock.
// - As transmitter, master acknowledge is latched into received ack flag.
// - Transmitter without acknowledge releases SDA and waits for STOP.
// - Slave mode, enable, own address and interrupt enables set before use.
// - Mode field value 110 selects I2C slave; other codes leave it idle.
//
// Added by the designer: the AXI4-Lite register port and the register addresses.
module sis_i2c_slave import sis_pkg::*; (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              scl_i,
  output logic                   scl_o,
  output logic                   scl_oe,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe,
  output logic                   irq
);
  logic [1:0]  pins_s;
  sis_bus_ev_t ev;
  sis_state_t  state_q;
  logic [3:0]  cnt_q;
  logic [7:0]  shreg_q;
  logic        ack_rise_q;
  logic [7:0]  data_q;
  logic [7:0]  own_addr_q;
  sis_status_t stat_q;
  sis_ctrl0_t  ctrl0_q;
  logic [7:0]  irq_q;
  logic        pend_set;

  sis_sync #(.W(2)) u_sync (
    .clock (clock),
    .rst   (rst),
    .d     ({scl_i, sda_i}),
    .q     (pins_s)
  );

  sis_edge u_edge (
    .clock (clock),
    .rst   (rst),
    .scl_s (pins_s[1]),
    .sda_s (pins_s[0]),
    .ev    (ev)
  );

  // Write channel: address and data latched independently, either order
  logic [ADDR_W-1:0] aw_addr_q;
  logic [7:0]        w_data_q;
  logic              w_lane0_q;
  logic              aw_full_q;
  logic              w_full_q;
  logic              awready_q;
  logic              wready_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  wire               aw_take   = s_axi_awvalid & awready_q;
  wire               w_take    = s_axi_wvalid & wready_q;
  wire               wr_do     = aw_full_q & w_full_q;
  wire               aw_full_d = aw_take | (aw_full_q & ~wr_do);
  wire               w_full_d  = w_take | (w_full_q & ~wr_do);
  wire               bvalid_d  = wr_do | (bvalid_q & ~s_axi_bready);
  wire [7:0]         wa        = {aw_addr_q[ADDR_W-1:2], 2'h0};
  wire               wr_en     = wr_do & w_lane0_q;
  wire               wr_data   = wr_en & (wa == OFF_DATA);
  wire               wr_own    = wr_en & (wa == OFF_OWN_ADDR);
  wire               wr_stat   = wr_en & (wa == OFF_STATUS);
  wire               wr_ctrl   = wr_en & (wa == OFF_CTRL0);
  wire               wr_irq    = wr_en & (wa == OFF_IRQ);
  wire               wa_hit    = (wa == OFF_DATA) | (wa == OFF_OWN_ADDR) | (wa == OFF_STATUS) |
                                 (wa == OFF_CTRL0) | (wa == OFF_IRQ);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      aw_addr_q <= '0;
      w_data_q  <= 8'h00;
      w_lane0_q <= 1'b0;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      awready_q <= ~aw_full_d & ~bvalid_d;
      wready_q  <= ~w_full_d & ~bvalid_d;
      bvalid_q  <= bvalid_d;
      if (aw_take) aw_addr_q <= s_axi_awaddr;
      if (w_take) begin
        w_data_q  <= s_axi_wdata[7:0];
        w_lane0_q <= s_axi_wstrb[0];
      end
      if (wr_do) bresp_q <= wa_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // Read channel: data registered at address acceptance
  logic        arready_q;
  logic        rvalid_q;
  logic [7:0]  rdata_q;
  logic [1:0]  rresp_q;
  wire         ar_take  = s_axi_arvalid & arready_q;
  wire         rvalid_d = ar_take | (rvalid_q & ~s_axi_rready);
  wire [7:0]   ra       = {s_axi_araddr[ADDR_W-1:2], 2'h0};
  wire         rd_data  = ar_take & (ra == OFF_DATA);
  wire         ra_hit   = (ra == OFF_DATA) | (ra == OFF_OWN_ADDR) | (ra == OFF_STATUS) |
                          (ra == OFF_CTRL0) | (ra == OFF_IRQ);
  wire [7:0]   rd_mux   = (ra == OFF_DATA)     ? data_q :
                          (ra == OFF_OWN_ADDR) ? own_addr_q :
                          (ra == OFF_STATUS)   ? stat_q :
                          (ra == OFF_CTRL0)    ? ctrl0_q :
                          (ra == OFF_IRQ)      ? irq_q : 8'h00;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 8'h00;
      rresp_q   <= RESP_OKAY;
    end else begin
      arready_q <= ~rvalid_d;
      rvalid_q  <= rvalid_d;
      if (ar_take) begin
        rdata_q <= rd_mux;
        rresp_q <= ra_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Bus engine
  wire       active   = ctrl0_q.enable & (ctrl0_q.mode == MODE_I2C_SLV);
  wire [7:0] rx_byte  = {shreg_q[6:0], ev.sda};
  wire       last_bit = ev.scl_rise & (cnt_q == BITS_PER_BYTE - 4'h1);
  wire       addr_hit = (state_q == ST_ADDR) & last_bit & (shreg_q[6:0] == own_addr_q[7:1]);
  wire       release_hold = stat_q.tx_sel ? wr_data : rd_data;
  wire       ack_end  = (state_q == ST_DACK) & ev.scl_fall & ack_rise_q;
  logic      scl_oe_q;
  logic      sda_oe_q;

  assign pend_set = addr_hit | ack_end;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q    <= ST_IDLE;
      cnt_q      <= 4'h0;
      shreg_q    <= 8'h00;
      ack_rise_q <= 1'b0;
      scl_oe_q   <= 1'b0;
      sda_oe_q   <= 1'b0;
    end else if (!active || ev.stop) begin
      state_q  <= ST_IDLE;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (ev.start) begin
      state_q  <= ST_ADDR;
      cnt_q    <= 4'h0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else begin
      case (state_q)
        ST_ADDR: begin
          if (ev.scl_rise) begin
            shreg_q <= rx_byte;
            cnt_q   <= cnt_q + 4'h1;
          end
          if (last_bit) begin
            ack_rise_q <= 1'b0;
            state_q    <= addr_hit ? ST_AACK : ST_WSTOP;
          end
        end
        ST_AACK, ST_DACK: begin
          if (ev.scl_rise) ack_rise_q <= 1'b1;
          if (ev.scl_fall && !ack_rise_q) begin
            if (state_q == ST_AACK) sda_oe_q <= 1'b1;
            else sda_oe_q <= ~stat_q.tx_sel & ~stat_q.transmitted_ack_bit;
          end
          if (ev.scl_fall && ack_rise_q) begin
            sda_oe_q <= 1'b0;
            // Stretch only while the master still wants bytes
            if (state_q == ST_DACK && stat_q.tx_sel && stat_q.received_ack_flag) begin
              state_q <= ST_WSTOP;
            end else begin
              state_q  <= ST_HOLD;
              scl_oe_q <= 1'b1;
            end
          end
        end
        ST_HOLD: begin
          if (release_hold) begin
            scl_oe_q <= 1'b0;
            cnt_q    <= 4'h0;
            state_q  <= ST_DATA;
            // Buffer takes the byte on this same edge, so send the byte being written
            shreg_q  <= w_data_q;
            if (stat_q.tx_sel) sda_oe_q <= ~w_data_q[7];
          end
        end
        ST_DATA: begin
          if (ev.scl_rise) begin
            cnt_q <= cnt_q + 4'h1;
            if (!stat_q.tx_sel) shreg_q <= rx_byte;
          end
          if (ev.scl_fall && stat_q.tx_sel) begin
            shreg_q  <= {shreg_q[6:0], 1'b0};
            sda_oe_q <= ~shreg_q[6];
          end
          if (last_bit) begin
            ack_rise_q <= 1'b0;
            state_q    <= ST_DACK;
          end
        end
        ST_WSTOP: sda_oe_q <= 1'b0;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Registers and flags; hardware set wins over any clear
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      data_q     <= RST_DATA;
      own_addr_q <= RST_OWN_ADDR;
      stat_q     <= '0;
      ctrl0_q    <= RST_CTRL0;
      irq_q      <= 8'h00;
    end else begin
      if (wr_data) data_q <= w_data_q;
      if (state_q == ST_DATA && last_bit && !stat_q.tx_sel) data_q <= rx_byte;
      if (wr_own) own_addr_q <= w_data_q;
      if (wr_ctrl) ctrl0_q <= w_data_q;
      if (wr_stat) begin
        stat_q.tx_sel <= w_data_q[4];
        stat_q.transmitted_ack_bit   <= w_data_q[3];
        stat_q.wake   <= w_data_q[1];
      end
      if (wr_data || rd_data) stat_q.done <= 1'b0;
      if (ack_end) begin
        stat_q.done  <= 1'b1;
        stat_q.match <= 1'b0;
      end
      if (addr_hit) begin
        stat_q.match <= 1'b1;
        stat_q.rw    <= ev.sda;
      end
      if (state_q == ST_DACK && ev.scl_rise && stat_q.tx_sel) stat_q.received_ack_flag <= ev.sda;
      if (ev.stop || !active) stat_q.busy <= 1'b0;
      if (ev.start && active) stat_q.busy <= 1'b1;
      if (wr_irq) begin
        irq_q[IRQ_MODULE_INTERRUPT_ENABLE_BIT] <= w_data_q[IRQ_MODULE_INTERRUPT_ENABLE_BIT];
        irq_q[IRQ_MFE_BIT]  <= w_data_q[IRQ_MFE_BIT];
        if (w_data_q[IRQ_PEND_BIT]) irq_q[IRQ_PEND_BIT] <= 1'b0;
      end
      if (pend_set) irq_q[IRQ_PEND_BIT] <= 1'b1;
    end
  end

  // Outputs straight from flip-flops
  logic irq_out_q;
  logic pin_low_q;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_out_q <= 1'b0;
      pin_low_q <= 1'b0;
    end else begin
      irq_out_q <= irq_q[IRQ_PEND_BIT] & irq_q[IRQ_MODULE_INTERRUPT_ENABLE_BIT] & irq_q[IRQ_MFE_BIT];
      pin_low_q <= 1'b0;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = {24'h000000, rdata_q};
  assign s_axi_rresp   = rresp_q;
  assign scl_oe        = scl_oe_q;
  assign sda_oe        = sda_oe_q;
  assign scl_o         = pin_low_q;
  assign sda_o         = pin_low_q;
  assign irq           = irq_out_q;

  a_busy_on_start: assert property (@(posedge clock) disable iff (rst)
    (ev.start && active && !ev.stop) |=> stat_q.busy) else $error("busy not set by start");
  a_busy_off_stop: assert property (@(posedge clock) disable iff (rst)
    ev.stop |=> !stat_q.busy) else $error("busy not cleared by stop");
  a_match_flag_irq: assert property (@(posedge clock) disable iff (rst)
    (addr_hit && active && !ev.stop && !ev.start) |=> stat_q.match && irq_q[IRQ_PEND_BIT] && state_q == ST_AACK)
    else $error("match not flagged");
  a_rw_capture: assert property (@(posedge clock) disable iff (rst)
    addr_hit |=> stat_q.rw == $past(ev.sda)) else $error("rw bit not captured");
  a_addr_ack_low: assert property (@(posedge clock) disable iff (rst)
    (state_q == ST_AACK && ev.scl_rise && active && !ev.stop) |-> sda_oe_q) else $error("no address ack");
  a_hold_scl_low: assert property (@(posedge clock) disable iff (rst)
    (state_q == ST_HOLD && !release_hold && active && !ev.stop && !ev.start) |=> scl_oe_q)
    else $error("scl not held");
  a_received_ack_flag_latch: assert property (@(posedge clock) disable iff (rst)
    (state_q == ST_DACK && ev.scl_rise && stat_q.tx_sel) |=> stat_q.received_ack_flag == $past(ev.sda))
    else $error("received_ack_flag not latched");
  a_nack_release: assert property (@(posedge clock) disable iff (rst)
    (state_q == ST_WSTOP) |=> !sda_oe_q) else $error("sda not released");
  a_mode_gate: assert property (@(posedge clock) disable iff (rst)
    !active |=> state_q == ST_IDLE && !scl_oe_q && !sda_oe_q) else $error("engine active out of mode");
  a_own_addr_wr: assert property (@(posedge clock) disable iff (rst)
    wr_own |=> own_addr_q == $past(w_data_q)) else $error("own address not stored");

  c_addr_match: cover property (@(posedge clock) disable iff (rst) addr_hit);
  c_tx_byte: cover property (@(posedge clock) disable iff (rst) ack_end && stat_q.tx_sel);
  c_rx_byte: cover property (@(posedge clock) disable iff (rst) ack_end && !stat_q.tx_sel);
endmodule

// ==== dv/sis_i2c_master.sv ====
// Behavioural I2C bus master on open-drain SCL and SDA
module sis_i2c_master (
  input  wire logic scl_w,
  input  wire logic sda_w,
  output logic      scl_lo,
  output logic      sda_lo
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int Q = 40;
  int stalls = 0;
  // Both lines released at start; SCL stands still between frames
  initial begin
    scl_lo = 1'b0;
    sda_lo = 1'b0;
  end
  // One 160 ns bit; bounded wait so a stuck stretch cannot hang the run
  task automatic clk_bit(input logic b, output logic s);
    int n;
    sda_lo = !b;
    #Q;
    scl_lo = 1'b0;
    n = 0;
    while (scl_w !== 1'b1 && n < 400) begin
      #5;
      n++;
    end
    if (n == 400) stalls++;
    #(2*Q);
    s = sda_w;
    scl_lo = 1'b1;
    #Q;
  endtask
  // Bus must be idle; only this side makes a START
  task automatic start_cond();
    sda_lo = 1'b1;
    #Q;
    scl_lo = 1'b1;
    #Q;
  endtask
  // Also used after a refused address
  task automatic stop_cond();
    sda_lo = 1'b1;
    #Q;
    scl_lo = 1'b0;
    #Q;
    sda_lo = 1'b0;
    #Q;
  endtask
  task automatic write_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
    clk_bit(1'b1, ack);
  endtask
  task automatic read_byte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
    clk_bit(nack, s);
  endtask
endmodule

// ==== dv/sis_i2c_slave_tb_top.sv ====
// Bench for the I2C slave: register tasks, bus master partner, scenarios
module sis_i2c_slave_tb_top import sis_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic              clock;
  logic              rst;
  logic [ADDR_W-1:0] s_axi_awaddr;
  logic              s_axi_awvalid;
  logic              s_axi_awready;
  logic [31:0]       s_axi_wdata;
  logic [3:0]        s_axi_wstrb;
  logic              s_axi_wvalid;
  logic              s_axi_wready;
  logic [1:0]        s_axi_bresp;
  logic              s_axi_bvalid;
  logic              s_axi_bready;
  logic [ADDR_W-1:0] s_axi_araddr;
  logic              s_axi_arvalid;
  logic              s_axi_arready;
  logic [31:0]       s_axi_rdata;
  logic [1:0]        s_axi_rresp;
  logic              s_axi_rvalid;
  logic              s_axi_rready;
  logic              scl_o;
  logic              scl_oe;
  logic              sda_o;
  logic              sda_oe;
  logic              irq;
  logic              scl_lo;
  logic              sda_lo;
  wire               scl_w;
  wire               sda_w;
  int                errors;
  int                check_count;
  logic [7:0]        v;
  logic [1:0]        r;
  logic              a;
  // Pull-ups: a line is low while any party pulls it
  assign scl_w = !(scl_lo || (scl_oe && !scl_o));
  assign sda_w = !(sda_lo || (sda_oe && !sda_o));
  sis_i2c_slave sis_i2c_slave_inst (
    .clock(clock), .rst(rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq)
  );
  sis_i2c_master sis_i2c_master_inst (.scl_w(scl_w), .sda_w(sda_w), .scl_lo(scl_lo), .sda_lo(sda_lo));
  always #2.5 clock = ~clock;
  task automatic complete_run();
    $display("Checks %0d, errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string w);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t ns: %s got %h expected %h", $time, w, got, exp);
    end
  endtask
  task automatic hang();
    errors++;
    $display("Error at %0t ns: bus answer missing", $time);
    complete_run();
  endtask
  // Address and data offered together, each released once taken
  task automatic wr(input logic [7:0] ad, input logic [7:0] d, input logic [1:0] er);
    int n;
    logic pa;
    logic pw;
    pa = 1'b1;
    pw = 1'b1;
    n = 0;
    @(posedge clock);
    s_axi_awaddr <= ad;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge clock);
      n++;
      pa = pa && !s_axi_awready;
      pw = pw && !s_axi_wready;
      s_axi_awvalid <= pa;
      s_axi_wvalid <= pw;
      if (s_axi_bvalid || n > 200) break;
    end
    s_axi_bready <= 1'b0;
    if (n > 200) hang();
    chk({6'h0, s_axi_bresp}, {6'h0, er}, "write response");
  endtask
  task automatic rd(input logic [7:0] ad, output logic [7:0] d, output logic [1:0] rs);
    int n;
    logic pa;
    pa = 1'b1;
    n = 0;
    @(posedge clock);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge clock);
      n++;
      pa = pa && !s_axi_arready;
      s_axi_arvalid <= pa;
      if (s_axi_rvalid || n > 200) break;
    end
    s_axi_rready <= 1'b0;
    if (n > 200) hang();
    d = s_axi_rdata[7:0];
    rs = s_axi_rresp;
  endtask
  // Masked read compare; flags of other phases may linger
  task automatic rc(input logic [7:0] ad, input logic [7:0] m, input logic [7:0] e, input string w);
    logic [7:0] d;
    logic [1:0] rs;
    rd(ad, d, rs);
    chk(d & m, e, w);
  endtask
  initial begin
    clock = 1'b0;
    rst = 1'b1;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    errors = 0;
    check_count = 0;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    rc(OFF_DATA, 8'hff, RST_DATA, "data reset");
    rc(OFF_OWN_ADDR, 8'hff, RST_OWN_ADDR, "own address reset");
    rc(OFF_STATUS, 8'hff, 8'h00, "status reset");
    rc(OFF_CTRL0, 8'hff, RST_CTRL0, "control reset");
    rd(8'h14, v, r);
    chk({6'h0, r}, {6'h0, RESP_SLVERR}, "unmapped read");
    wr(8'h14, 8'hff, RESP_SLVERR);
    wr(OFF_CTRL0, {MODE_I2C_SLV, 5'h02}, RESP_OKAY);
    wr(OFF_OWN_ADDR, 8'ha5, RESP_OKAY);
    wr(OFF_IRQ, 8'h03, RESP_OKAY);
    rc(OFF_OWN_ADDR, 8'hff, 8'ha5, "own address bit 0");
    // Low byte lane off: the write is answered but has no effect
    s_axi_wstrb <= 4'he;
    wr(OFF_OWN_ADDR, 8'h00, RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rc(OFF_OWN_ADDR, 8'hff, 8'ha5, "lane masked write");
    // Foreign address: no ack, no interrupt
    sis_i2c_master_inst.start_cond();
    rc(OFF_STATUS, 8'hff, 8'h20, "busy after start");
    sis_i2c_master_inst.write_byte(8'ha6, a);
    chk({7'h0, a}, 8'h01, "foreign address ack");
    chk({7'h0, irq}, 8'h00, "foreign irq");
    sis_i2c_master_inst.stop_cond();
    rc(OFF_STATUS, 8'hff, 8'h00, "busy after stop");
    // Master writes two bytes, second refused through the ack bit
    sis_i2c_master_inst.start_cond();
    sis_i2c_master_inst.write_byte(8'ha4, a);
    chk({7'h0, a}, 8'h00, "address ack");
    chk({7'h0, irq}, 8'h01, "match irq");
    rc(OFF_STATUS, 8'hfe, 8'h60, "match, master writes");
    wr(OFF_IRQ, 8'h83, RESP_OKAY);
    wr(OFF_STATUS, 8'h00, RESP_OKAY);
    chk({7'h0, scl_oe}, 8'h01, "scl held");
    rd(OFF_DATA, v, r);
    repeat (2) @(posedge clock);
    chk({7'h0, scl_oe}, 8'h00, "scl freed by read");
    chk({7'h0, irq}, 8'h00, "irq cleared");
    sis_i2c_master_inst.write_byte(8'h3c, a);
    chk({7'h0, a}, 8'h00, "data ack");
    chk({7'h0, irq}, 8'h01, "byte irq");
    rc(OFF_STATUS, 8'hfe, 8'ha0, "byte done, match clear");
    rc(OFF_DATA, 8'hff, 8'h3c, "received byte");
    wr(OFF_IRQ, 8'h83, RESP_OKAY);
    wr(OFF_STATUS, 8'h08, RESP_OKAY);
    sis_i2c_master_inst.write_byte(8'h81, a);
    chk({7'h0, a}, 8'h01, "ack bit sent high");
    rc(OFF_DATA, 8'hff, 8'h81, "second byte");
    sis_i2c_master_inst.stop_cond();
    rc(OFF_STATUS, 8'he0, 8'h00, "idle after stop");
    // Master reads two bytes, refusing the second
    wr(OFF_IRQ, 8'h83, RESP_OKAY);
    wr(OFF_STATUS, 8'h00, RESP_OKAY);
    sis_i2c_master_inst.start_cond();
    sis_i2c_master_inst.write_byte(8'ha5, a);
    chk({7'h0, a}, 8'h00, "read address ack");
    rc(OFF_STATUS, 8'hfe, 8'h64, "match, master reads");
    wr(OFF_STATUS, 8'h10, RESP_OKAY);
    wr(OFF_DATA, 8'ha6, RESP_OKAY);
    sis_i2c_master_inst.read_byte(1'b0, v);
    chk(v, 8'ha6, "sent byte");
    rc(OFF_STATUS, 8'hff, 8'hb4, "master acked");
    wr(OFF_DATA, 8'h5b, RESP_OKAY);
    sis_i2c_master_inst.read_byte(1'b1, v);
    chk(v, 8'h5b, "last byte");
    rc(OFF_STATUS, 8'hff, 8'hb5, "master refused");
    chk({7'h0, sda_oe}, 8'h00, "sda freed");
    chk({7'h0, scl_oe}, 8'h00, "no stretch");
    sis_i2c_master_inst.stop_cond();
    // Done flag stays up: no buffer access since the refused byte
    rc(OFF_STATUS, 8'he0, 8'h80, "free after read");
    // Other mode code: slave stays deaf
    wr(OFF_CTRL0, 8'ha2, RESP_OKAY);
    sis_i2c_master_inst.start_cond();
    sis_i2c_master_inst.write_byte(8'ha4, a);
    chk({7'h0, a}, 8'h01, "spi mode ack");
    sis_i2c_master_inst.stop_cond();
    chk(sis_i2c_master_inst.stalls[7:0], 8'h00, "clock stalls");
    complete_run();
  end
endmodule
